// ==== common/fai_pkg.sv ====
// shared constants and carriers for the fifo access instruction unit
// assumes one ref clock domain plus the spi link clock
package fai_pkg;
   // instruction opcodes
   localparam logic [7:0] RX_FIFO_READ_INSTR      = 8'h30;
   localparam logic [7:0] RX_FIFO_READ_COPY_INSTR = 8'h32;
   localparam logic [7:0] RX_FIFO_MOVE_INSTR      = 8'h38;
   localparam logic [7:0] TX_FIFO_WRITE_INSTR     = 8'h3a;
   localparam logic [7:0] RANDOM_INSTR            = 8'h3c;
   // fifo shape
   localparam int FIFO_W     = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W      = 5;
   // move operand byte 1 field positions
   localparam int PRIO_BIT   = 7;
   localparam int ADDR_HI_MSB = 3;
   // reset values
   localparam logic [15:0] LFSR_SEED  = 16'hace1;
   localparam logic [7:0]  STATUS_RST = 8'h00;

   typedef enum logic [2:0] {
      CMD_IDLE, CMD_TXW, CMD_RXR, CMD_RXC, CMD_RND, CMD_MOV, CMD_IGN
   } fai_cmd_t;

   typedef struct packed {
      logic tx_overflow;
      logic rx_underflow;
      logic move_timeout_exc;
      logic low_prio_done_exc;
      logic high_prio_done_exc;
      logic priority_busy_exc;
   } fai_exc_t;

   typedef struct packed {
      logic        busy;
      logic [11:0] addr;
      logic [7:0]  cnt;
   } fai_slot_t;

   typedef struct packed {
      logic        we;
      logic [11:0] addr;
      logic [7:0]  data;
   } fai_mem_wr_t;
endpackage : fai_pkg

// ==== core/fai_top.sv ====
// fifo access instruction unit: spi byte link, tx/rx fifos, background move
// assumes spi mode with mosi sampled and miso changed on sclk rising edge,
// and sclk held still at least 8 ref cycles between bytes
//
// Summary of operation
// [R1] host avoids plain/copy read during move
// [R2] tx write bytes appended in order
// [R3] tx write returns count before each byte
// [R4] tx write while full raises overflow
// [R5] random read returns noise-seeded bytes
// [R6] move copies count oldest bytes to address
// [R7] move priority bit: zero low, one high
// [R8] move timeout when fifo empties, per select
// [R9] remaining byte count visible after early end
// [R10] high move with select one holds unit
// [R11] done exception matches move priority
// [R12] move on busy priority raises priority_busy_exc
// [R13] plain read pops byte, underflow if empty
// [R14] copy read also writes memory, returns count
// [R15] move runs in background after frame; code starts it once the count byte arrives, inside the frame
`timescale 1ns/1ps

module fai_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       in_valid_i,
   input  wire logic [W-1:0]               in_data_i,
   output logic                            in_ready_o,
   output logic                            out_valid_o,
   output logic [W-1:0]                    out_data_o,
   input  wire logic                       out_ready_i,
   output logic [$clog2(DEPTH):0]          count_o
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wr;
      logic [AW-1:0]           rd;
      logic [AW:0]             cnt;
   } fai_fifo_st_t;
   fai_fifo_st_t q_reg, q_next;
   logic push, pop;

   always_comb begin
      q_next = q_reg;
      push = in_valid_i && (q_reg.cnt != (AW+1)'(DEPTH));
      pop  = out_ready_i && (q_reg.cnt != '0);
      if (push) begin
         q_next.mem[q_reg.wr] = in_data_i;
         q_next.wr = q_reg.wr + 1'b1;
      end
      if (pop) q_next.rd = q_reg.rd + 1'b1;
      q_next.cnt = q_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign in_ready_o  = q_reg.cnt != (AW+1)'(DEPTH);
   assign out_valid_o = q_reg.cnt != '0;
   assign out_data_o  = q_reg.mem[q_reg.rd];
   assign count_o     = q_reg.cnt;
endmodule : fai_fifo

module fai_top (
   // clock and reset
   input  wire logic                REF_CLK_I,
   input  wire logic                SYS_RST_I,
   // spi link
   input  wire logic                SPI_SCLK_I,
   input  wire logic                SPI_CS_N_I,
   input  wire logic                SPI_MOSI_I,
   output logic                     SPI_MISO_O,
   // radio receive side
   input  wire logic                RX_VALID_I,
   input  wire logic [7:0]          RX_DATA_I,
   output logic                     RX_READY_O,
   input  wire logic                FRAME_DONE_I,
   input  wire logic                NOISE_I,
   input  wire logic                RX_TIMEOUT_SELECT_I,
   // radio transmit side
   output logic                     TX_VALID_O,
   output logic [7:0]               TX_DATA_O,
   input  wire logic                TX_READY_I,
   // memory write port and events
   output fai_pkg::fai_mem_wr_t     MEM_WR_O,
   output fai_pkg::fai_exc_t        EXC_O,
   output logic [7:0]               REMAIN_O
);
   import fai_pkg::*;

   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [6:0] shift_in;
      logic [7:0] shift_out;
   } fai_spi_t;
   typedef struct packed {
      logic [7:0] rx_byte;
      logic [1:0] gray;
   } fai_spix_t;
   typedef struct packed {
      fai_cmd_t    cmd;
      logic [2:0]  idx;
      logic [1:0]  gray_s1, gray_s2, gray_seen;
      logic        cs_s1, cs_s2, noise_s1, noise_s2, tim_s1, tim_s2;
      logic [7:0]  reply;
      logic [11:0] addr;
      logic        cp_pend;
      logic        peek, pop_pend, peek_ok;
      logic [7:0]  cp_data;
      logic [11:0] cp_off;
      logic        mov_prio;
      fai_slot_t   slot_l, slot_h;
      logic [15:0] lfsr;
      fai_exc_t    exc;
      fai_mem_wr_t mem;
      logic [7:0]  remain;
   } fai_sys_t;

   fai_spi_t  s_reg, s_next;
   fai_spix_t x_reg, x_next;
   fai_sys_t  q_reg, q_next;
   logic [CNT_W-1:0] tx_count, rx_count;
   logic             tx_push, tx_in_ready, rx_pop, rx_out_valid;
   logic [7:0]       rx_head, rnd;
   logic             byte_ev, want_pop, mem_busy, sel_h, frame_quiet;
   fai_slot_t        slot;

   // link side: bit counter cleared by chip select between frames
   always_comb begin
      s_next = s_reg;
      x_next = x_reg;
      s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
      s_next.shift_in = {s_reg.shift_in[5:0], SPI_MOSI_I};
      // reply byte is quasi-static: it only changes while sclk is still
      if (s_reg.bit_cnt == 3'h0) s_next.shift_out = q_reg.reply;
      else s_next.shift_out = {s_reg.shift_out[6:0], 1'b0};
      if (s_reg.bit_cnt == 3'h7) begin
         x_next.rx_byte = {s_reg.shift_in, SPI_MOSI_I};
         x_next.gray = {x_reg.gray[0], ~x_reg.gray[1]};
      end
   end

   always_ff @(posedge SPI_SCLK_I or posedge SPI_CS_N_I) begin
      if (SPI_CS_N_I) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // byte pointer survives chip select so the last byte is never lost
   // system reset only lands while sclk is idle, so the async clear is safe
   always_ff @(posedge SPI_SCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         x_reg <= '0;
      end else begin
         x_reg <= x_next;
      end
   end

   assign SPI_MISO_O = s_reg.shift_out[7];

   fai_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk_i       (REF_CLK_I),
      .rst_i       (SYS_RST_I),
      .in_valid_i  (tx_push),
      .in_data_i   (x_reg.rx_byte),
      .in_ready_o  (tx_in_ready),
      .out_valid_o (TX_VALID_O),
      .out_data_o  (TX_DATA_O),
      .out_ready_i (TX_READY_I),
      .count_o     (tx_count)
   );

   fai_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk_i       (REF_CLK_I),
      .rst_i       (SYS_RST_I),
      .in_valid_i  (RX_VALID_I),
      .in_data_i   (RX_DATA_I),
      .in_ready_o  (RX_READY_O),
      .out_valid_o (rx_out_valid),
      .out_data_o  (rx_head),
      .out_ready_i (rx_pop),
      .count_o     (rx_count)
   );

   assign rnd = q_reg.lfsr[7:0];
   assign byte_ev = !q_reg.cs_s2 && (q_reg.gray_s2 != q_reg.gray_seen);
   assign sel_h = q_reg.slot_h.busy;
   assign slot = sel_h ? q_reg.slot_h : q_reg.slot_l;
   assign frame_quiet = !q_reg.tim_s2 || FRAME_DONE_I;

   always_comb begin
      q_next = q_reg;
      q_next.exc = '0;
      q_next.mem.we = 1'b0;
      tx_push = 1'b0;
      rx_pop = 1'b0;
      want_pop = 1'b0;
      mem_busy = 1'b0;
      q_next.gray_s1 = x_reg.gray;
      q_next.gray_s2 = q_reg.gray_s1;
      q_next.cs_s1 = SPI_CS_N_I;
      q_next.cs_s2 = q_reg.cs_s1;
      q_next.noise_s1 = NOISE_I;
      q_next.noise_s2 = q_reg.noise_s1;
      q_next.tim_s1 = RX_TIMEOUT_SELECT_I;
      q_next.tim_s2 = q_reg.tim_s1;
      q_next.lfsr = {q_reg.lfsr[14:0], q_reg.lfsr[15] ^ q_reg.lfsr[13] ^ q_reg.lfsr[12]
                     ^ q_reg.lfsr[10] ^ q_reg.noise_s2}; // [R5]
      // pending copy byte goes to memory at the next byte or frame end
      if (q_reg.cp_pend && (byte_ev || q_reg.cs_s2)) begin
         q_next.mem.we = 1'b1; // [R14]
         q_next.mem.addr = ((q_reg.cmd == CMD_RXC && q_reg.idx == 3'h2) ?
                            {q_reg.addr[11:8], x_reg.rx_byte} : q_reg.addr) + q_reg.cp_off;
         q_next.mem.data = q_reg.cp_data;
         q_next.cp_off = q_reg.cp_off + 12'h1;
         q_next.cp_pend = 1'b0;
         mem_busy = 1'b1;
      end
      if (q_reg.cs_s2) begin
         q_next.cmd = CMD_IDLE;
         q_next.idx = 3'h0;
         q_next.reply = STATUS_RST;
         q_next.gray_seen = q_reg.gray_s2;
         q_next.cp_off = 12'h0;
         q_next.pop_pend = 1'b0;
      end else if (byte_ev) begin
         q_next.gray_seen = q_reg.gray_s2;
         if (q_reg.idx != 3'h4) q_next.idx = q_reg.idx + 3'h1;
         if (q_reg.idx == 3'h0) begin
            q_next.reply = 8'h00;
            if (x_reg.rx_byte == TX_FIFO_WRITE_INSTR) begin
               q_next.cmd = CMD_TXW;
               q_next.reply = 8'(tx_count); // [R3]
            end else if (x_reg.rx_byte == RX_FIFO_READ_INSTR) begin
               q_next.cmd = CMD_RXR;
               want_pop = 1'b1; // [R13]
            end else if (x_reg.rx_byte == RX_FIFO_READ_COPY_INSTR) begin
               q_next.cmd = CMD_RXC;
               q_next.reply = 8'(rx_count); // [R14]
            end else if (x_reg.rx_byte == RANDOM_INSTR) begin
               q_next.cmd = CMD_RND;
               q_next.reply = rnd; // [R5]
            end else if (x_reg.rx_byte == RX_FIFO_MOVE_INSTR) begin
               q_next.cmd = CMD_MOV;
               q_next.reply = 8'(rx_count);
            end else begin
               q_next.cmd = CMD_IGN;
            end
         end else begin
            case (q_reg.cmd)
               CMD_TXW: begin
                  if (!tx_in_ready) begin
                     q_next.exc.tx_overflow = 1'b1; // [R4]
                     q_next.reply = 8'(tx_count);
                  end else begin
                     tx_push = 1'b1; // [R2]
                     q_next.reply = 8'(tx_count) + 8'h1; // [R3]
                  end
               end
               CMD_RXR: want_pop = 1'b1; // [R13]
               CMD_RXC: begin
                  if (q_reg.idx == 3'h1) q_next.addr[11:8] = x_reg.rx_byte[ADDR_HI_MSB:0];
                  if (q_reg.idx == 3'h2) q_next.addr[7:0] = x_reg.rx_byte;
                  want_pop = 1'b1; // [R14]
               end
               CMD_RND: q_next.reply = rnd; // [R5]
               CMD_MOV: begin
                  if (q_reg.idx == 3'h1) begin
                     q_next.mov_prio = x_reg.rx_byte[PRIO_BIT]; // [R7]
                     q_next.addr[11:8] = x_reg.rx_byte[ADDR_HI_MSB:0];
                  end
                  if (q_reg.idx == 3'h2) q_next.addr[7:0] = x_reg.rx_byte;
               end
               default: q_next.reply = 8'h00;
            endcase
         end
      end
      // a peeked byte leaves the fifo only once its transfer has completed
      if (byte_ev && q_reg.pop_pend) begin
         q_next.pop_pend = 1'b0;
         if (q_reg.peek_ok) begin
            rx_pop = 1'b1; // [R13]
            q_next.cp_data = rx_head;
            q_next.cp_pend = (q_reg.cmd == CMD_RXC); // [R14]
         end else begin
            q_next.exc.rx_underflow = 1'b1; // [R13]
         end
      end
      q_next.peek = want_pop;
      if (q_reg.peek && !q_reg.cs_s2) begin
         q_next.pop_pend = 1'b1;
         q_next.peek_ok = rx_out_valid;
         q_next.reply = rx_out_valid ? rx_head : 8'h00;
      end
      // background engine, high priority slot served first
      if (slot.busy && !rx_pop && !q_reg.peek && !mem_busy) begin // [R15]
         if (slot.cnt == 8'h0) begin
            if (sel_h) q_next.slot_h.busy = 1'b0;
            else q_next.slot_l.busy = 1'b0;
            q_next.exc.high_prio_done_exc = sel_h; // [R11]
            q_next.exc.low_prio_done_exc = !sel_h;
         end else if (rx_out_valid) begin
            rx_pop = 1'b1; // [R6]
            q_next.mem.we = 1'b1;
            q_next.mem.addr = slot.addr;
            q_next.mem.data = rx_head;
            if (sel_h) begin
               q_next.slot_h.addr = slot.addr + 12'h1;
               q_next.slot_h.cnt = slot.cnt - 8'h1;
            end else begin
               q_next.slot_l.addr = slot.addr + 12'h1;
               q_next.slot_l.cnt = slot.cnt - 8'h1;
            end
         end else if (frame_quiet) begin
            // select one waits for the frame, stalling low work behind it
            q_next.exc.move_timeout_exc = 1'b1; // [R8] [R10]
            q_next.remain = slot.cnt; // [R9]
            q_next.exc.high_prio_done_exc = sel_h; // [R11]
            q_next.exc.low_prio_done_exc = !sel_h;
            if (sel_h) q_next.slot_h.busy = 1'b0;
            else q_next.slot_l.busy = 1'b0;
         end
      end
      if (byte_ev && q_reg.cmd == CMD_MOV && q_reg.idx == 3'h3) begin
         if (q_reg.mov_prio ? q_reg.slot_h.busy : q_reg.slot_l.busy) begin
            q_next.exc.priority_busy_exc = 1'b1; // [R12]
         end else if (q_reg.mov_prio) begin
            q_next.slot_h = '{busy: 1'b1, addr: q_reg.addr, cnt: x_reg.rx_byte}; // [R6]
         end else begin
            q_next.slot_l = '{busy: 1'b1, addr: q_reg.addr, cnt: x_reg.rx_byte};
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         q_reg <= '0;
         q_reg.lfsr <= LFSR_SEED;
         q_reg.cs_s1 <= 1'b1;
         q_reg.cs_s2 <= 1'b1;
      end else begin
         q_reg <= q_next;
      end
   end

   assign MEM_WR_O = q_reg.mem;
   assign EXC_O    = q_reg.exc;
   assign REMAIN_O = q_reg.remain;

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SYS_RST_I);

   property p_tx_append;
      tx_push && !(TX_VALID_O && TX_READY_I) |=> tx_count == $past(tx_count) + 5'h1;
   endproperty
   a_tx_append: assert property (p_tx_append) else $error("tx push not counted"); // [R2]

   property p_tx_first_count;
      byte_ev && q_reg.idx == 3'h0 && x_reg.rx_byte == TX_FIFO_WRITE_INSTR
         |=> q_reg.reply == 8'($past(tx_count));
   endproperty
   a_tx_first_count: assert property (p_tx_first_count) else $error("bad tx count reply"); // [R3]

   property p_tx_overflow;
      byte_ev && q_reg.cmd == CMD_TXW && q_reg.idx != 3'h0 && !tx_in_ready
         |=> q_reg.exc.tx_overflow && $stable(tx_count);
   endproperty
   a_tx_overflow: assert property (p_tx_overflow) else $error("missing tx overflow"); // [R4]

   property p_random;
      byte_ev && q_reg.cmd == CMD_RND |=> q_reg.reply == $past(rnd);
   endproperty
   a_random: assert property (p_random) else $error("random reply wrong"); // [R5]

   property p_move_write;
      slot.busy && !rx_pop && !q_reg.peek && !mem_busy && slot.cnt != 8'h0 && rx_out_valid
         |=> q_reg.mem.we && q_reg.mem.addr == $past(slot.addr);
   endproperty
   a_move_write: assert property (p_move_write) else $error("move write misplaced"); // [R6]

   property p_timeout_done;
      q_reg.exc.move_timeout_exc |-> (q_reg.exc.high_prio_done_exc ^ q_reg.exc.low_prio_done_exc)
         && !$past(rx_out_valid);
   endproperty
   a_timeout_done: assert property (p_timeout_done) else $error("timeout without done"); // [R8]

   property p_high_done;
      q_reg.slot_h.busy ##1 !q_reg.slot_h.busy |-> q_reg.exc.high_prio_done_exc;
   endproperty
   a_high_done: assert property (p_high_done) else $error("high move ended silently"); // [R11]

   property p_usage;
      byte_ev && q_reg.cmd == CMD_MOV && q_reg.idx == 3'h3 && q_reg.slot_l.busy
         && !q_reg.mov_prio |=> q_reg.exc.priority_busy_exc;
   endproperty
   a_usage: assert property (p_usage) else $error("priority_busy_exc missed"); // [R12]

   property p_underflow;
      byte_ev && q_reg.pop_pend && !q_reg.peek_ok |=> q_reg.exc.rx_underflow;
   endproperty
   a_underflow: assert property (p_underflow) else $error("underflow missed"); // [R13]

   property p_empty_reply;
      q_reg.peek && !q_reg.cs_s2 && !rx_out_valid |=> q_reg.reply == 8'h00;
   endproperty
   a_empty_reply: assert property (p_empty_reply) else $error("empty read reply"); // [R13]
endmodule : fai_top

// ==== verification/fai_spi_host.sv ====
// host spi master model driving the link side of the fifo access unit
// assumes mosi sampled and miso launched on sclk rising, sclk idle low
`timescale 1ns/1ps

module fai_spi_host (
   // link pins
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   // odd offset keeps the link phase unrelated to the ref clock
   task automatic open_frame();
      #3.7 cs_n_o = 1'b0;
      #300;
   endtask : open_frame

   task automatic xfer(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         mosi_o = b[i];
         #6 sclk_o = 1'b1;
         #6 sclk_o = 1'b0;
         r[i] = miso_i;
      end
      // a released data line must not keep showing its last bit
      mosi_o = ~mosi_o;
      // sclk stands still long enough for the ref side to catch up
      #300;
   endtask : xfer

   task automatic close_frame();
      cs_n_o = 1'b1;
      #200;
   endtask : close_frame
endmodule : fai_spi_host

// ==== verification/test_fai_top.sv ====
// self-checking bench for the fifo access instruction unit
// assumes the host model for the link and drives radio side at ref falling edge
`timescale 1ns/1ps

module test_fai_top;
   import fai_pkg::*;
   typedef struct packed {logic [7:0] op, d1, d2, e1, e2;} fai_row_t;
   localparam int e_busy = 0, e_high = 1, e_low = 2, e_tmo = 3, e_und = 4, e_ovf = 5;
   logic        ref_clk, sys_rst, sclk, cs_n, mosi, miso, noise;
   logic        rx_valid, rx_ready, frame_done, rx_sel, tx_valid, tx_ready;
   logic [7:0]  rx_data, tx_data, remain;
   fai_mem_wr_t mem_wr;
   fai_exc_t    exc;
   int          mismatches, n_tests;
   int          exc_cnt [6];
   fai_mem_wr_t mem_q [$];
   logic [7:0]  tx_q [$];
   fai_row_t    rows [5] = '{'{8'h3a, 8'h11, 8'h22, 8'h00, 8'h01},
                             '{8'h3a, 8'h33, 8'h44, 8'h02, 8'h03},
                             '{8'h30, 8'h00, 8'h00, 8'ha1, 8'ha2},
                             '{8'h32, 8'h00, 8'h40, 8'h02, 8'ha3},
                             '{8'h00, 8'h55, 8'h66, 8'h00, 8'h00}};

   fai_spi_host host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));

   fai_top dut (
      .REF_CLK_I(ref_clk), .SYS_RST_I(sys_rst), .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n),
      .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data),
      .RX_READY_O(rx_ready), .FRAME_DONE_I(frame_done), .NOISE_I(noise),
      .RX_TIMEOUT_SELECT_I(rx_sel), .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data),
      .TX_READY_I(tx_ready), .MEM_WR_O(mem_wr), .EXC_O(exc), .REMAIN_O(remain)
   );

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   always @(negedge ref_clk) noise <= ~noise;

   always @(negedge ref_clk) begin
      for (int i = 0; i < 6; i++) begin
         if (exc[i] === 1'b1) exc_cnt[i]++;
      end
      if (mem_wr.we === 1'b1) mem_q.push_back(mem_wr);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) tx_q.push_back(tx_data);
   end

   task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic frame(input logic [7:0] mo [$], output logic [7:0] mi [$]);
      logic [7:0] r;
      mi = {};
      host.open_frame();
      foreach (mo[i]) begin
         host.xfer(mo[i], r);
         mi.push_back(r);
      end
      host.close_frame();
      repeat (8) @(negedge ref_clk);
   endtask : frame

   task automatic push_rx(input logic [7:0] b);
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_data  = b;
      @(posedge ref_clk);
      while (rx_ready !== 1'b1) @(posedge ref_clk);
      @(negedge ref_clk);
      rx_valid = 1'b0;
   endtask : push_rx

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results

   initial begin
      #200us;
      mismatches++;
      results();
   end

   initial begin
      logic [7:0]  got [$];
      logic [7:0]  q [$];
      logic [11:0] a;
      {sys_rst, noise, rx_valid, rx_data, frame_done, rx_sel, tx_ready} = {1'b1, 13'h0};
      repeat (20) @(negedge ref_clk);
      sys_rst = 1'b0;
      check("exc after reset", 12'h000, 12'(exc));
      check("remain after reset", 12'h000, remain);
      repeat (4) @(negedge ref_clk);
      for (int i = 1; i <= 4; i++) push_rx(8'ha0 + 8'(i));
      // table rows: no move runs, so copy reads are safe
      foreach (rows[k]) begin
         frame('{rows[k].op, rows[k].d1, rows[k].d2}, got);
         check("status byte", 12'h000, got[0]);
         check("reply1", rows[k].e1, got[1]);
         check("reply2", rows[k].e2, got[2]);
         $display("row %0d done", k);
      end
      check("copy write addr", 12'h040, mem_q[0].addr);
      check("copy write data", 12'h0a3, mem_q[0].data);
      exc_cnt = '{default: 0};
      frame('{8'h30, 8'h00, 8'h00}, got);
      check("last rx byte", 12'h0a4, got[1]);
      check("empty read", 12'h000, got[2]);
      check("underflow", 12'h001, 12'(exc_cnt[e_und]));
      $display("underflow test done");
      q = '{8'h3a};
      for (int i = 0; i < 13; i++) q.push_back(8'(i));
      frame(q, got);
      for (int i = 1; i < 14; i++) check("tx count", 12'(i + 3), got[i]);
      check("overflow", 12'h001, 12'(exc_cnt[e_ovf]));
      @(negedge ref_clk);
      tx_ready = 1'b1;
      repeat (40) @(negedge ref_clk);
      q = '{8'h11, 8'h22, 8'h33, 8'h44};
      for (int i = 0; i < 12; i++) q.push_back(8'(i));
      check("tx drained", 12'd16, 12'(tx_q.size()));
      foreach (q[i]) check("tx order", q[i], tx_q[i]);
      $display("tx fill test done");
      frame('{8'h3c, 8'h00, 8'h00, 8'h00, 8'h00}, got);
      check("random varies", 12'h001, 12'(got[1] != got[2] || got[2] != got[3]));
      $display("random test done");
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 3; i++) push_rx(8'hc0 + 8'(p * 4 + i));
         a = (p == 1) ? 12'h320 : 12'h120;
         mem_q = {};
         exc_cnt = '{default: 0};
         frame('{8'h38, {p[0], 3'b000, a[11:8]}, a[7:0], 8'h03}, got);
         repeat (40) @(negedge ref_clk);
         for (int i = 0; i < 3; i++) begin
            check("move addr", a + 12'(i), mem_q[i].addr);
            check("move data", 12'h0c0 + 12'(p * 4 + i), mem_q[i].data);
         end
         check("low done", 12'(1 - p), 12'(exc_cnt[e_low]));
         check("high done", 12'(p), 12'(exc_cnt[e_high]));
         check("no timeout", 12'h000, 12'(exc_cnt[e_tmo]));
         $display("move priority %0d done", p);
      end
      push_rx(8'h5a);
      push_rx(8'h5b);
      mem_q = {};
      exc_cnt = '{default: 0};
      frame('{8'h38, 8'h02, 8'h00, 8'h05}, got);
      repeat (40) @(negedge ref_clk);
      check("early timeout", 12'h001, 12'(exc_cnt[e_tmo]));
      check("early done", 12'h001, 12'(exc_cnt[e_low]));
      check("remaining", 12'h003, remain);
      check("partial writes", 12'h002, 12'(mem_q.size()));
      $display("timeout test done");
      rx_sel = 1'b1;
      exc_cnt = '{default: 0};
      frame('{8'h38, 8'h83, 8'h00, 8'h02}, got);
      frame('{8'h38, 8'h83, 8'h00, 8'h02}, got);
      check("busy slot", 12'h001, 12'(exc_cnt[e_busy]));
      check("waits for frame", 12'h000, 12'(exc_cnt[e_tmo]));
      @(negedge ref_clk);
      frame_done = 1'b1;
      repeat (40) @(negedge ref_clk);
      check("frame timeout", 12'h001, 12'(exc_cnt[e_tmo]));
      check("high done", 12'h001, 12'(exc_cnt[e_high]));
      check("remaining", 12'h002, remain);
      $display("hold and usage test done");
      sys_rst = 1'b1;
      repeat (3) @(negedge ref_clk);
      check("remain in reset", 12'h000, remain);
      check("tx empty in reset", 12'h000, 12'(tx_valid));
      sys_rst = 1'b0;
      $display("second reset test done");
      results();
   end
endmodule : test_fai_top
